/* uart_pkg.sv */
// constants shared by the infrared serial channel
package uart_pkg;
   // register offsets on the 3-bit host address
   localparam logic [2:0] OFS_DATA = 3'h0;
   localparam logic [2:0] OFS_IER = 3'h1;
   localparam logic [2:0] OFS_IIR = 3'h2;
   localparam logic [2:0] OFS_LCR = 3'h3;
   localparam logic [2:0] OFS_MCR = 3'h4;
   localparam logic [2:0] OFS_LSR = 3'h5;
   localparam logic [2:0] OFS_MSR = 3'h6;
   localparam logic [2:0] OFS_SCR = 3'h7;
   // line control fields
   localparam int LCR_STOP = 2;
   localparam int LCR_PAR_EN = 3;
   localparam int LCR_EVEN = 4;
   localparam int LCR_STICK = 5;
   localparam int LCR_BREAK = 6;
   localparam int LCR_DIV_SEL = 7;
   // fifo control fields
   localparam int FCR_EN = 0;
   localparam int FCR_RX_RST = 1;
   localparam int FCR_TX_RST = 2;
   localparam int FCR_DMA = 3;
   // modem control fields
   localparam int MCR_DTR = 0;
   localparam int MCR_RTS = 1;
   localparam int MCR_AUX1 = 2;
   localparam int MCR_AUX2 = 3;
   localparam int MCR_LOOP = 4;
   // interrupt identification codes, low nibble
   localparam logic [3:0] IIR_NONE = 4'h1;
   localparam logic [3:0] IIR_LINE = 4'h6;
   localparam logic [3:0] IIR_RXDATA = 4'h4;
   localparam logic [3:0] IIR_TIMEOUT = 4'hc;
   localparam logic [3:0] IIR_TX_HOLDING_EMPTY = 4'h2;
   localparam logic [3:0] IIR_MODEM = 4'h0;
   // queue sizes and trigger levels
   localparam logic [4:0] FIFO_DEPTH = 5'h10;
   localparam logic [4:0] ONE_SLOT = 5'h01;
   localparam logic [4:0] TRIG_1 = 5'h01;
   localparam logic [4:0] TRIG_4 = 5'h04;
   localparam logic [4:0] TRIG_8 = 5'h08;
   localparam logic [4:0] TRIG_14 = 5'h0e;
   // serial timing in sixteenth-bit ticks
   localparam int TICKS_PER_BIT = 16;
   localparam logic [3:0] BIT_LAST = 4'hf;
   localparam logic [3:0] BIT_MID = 4'h7;
   localparam logic [3:0] BASE_BITS = 4'h7;
   localparam logic [3:0] FRAME_W = 4'hc;
   localparam int CHAR_BITS = 10;
   localparam int TURN_CHARS = 4;
   localparam int TIMEOUT_CHARS = 4;
   localparam logic [7:0] CHAR_TICKS = 8'(TICKS_PER_BIT * CHAR_BITS);
   localparam logic [9:0] TURN_TICKS =
      10'(TICKS_PER_BIT * CHAR_BITS * TURN_CHARS);
   localparam logic [9:0] TIMEOUT_TICKS =
      10'(TICKS_PER_BIT * CHAR_BITS * TIMEOUT_CHARS);
   localparam logic [3:0] IRDA_PULSE_TICKS = 4'h3;
   // carrier for keyed infrared
   localparam int CLK_HZ = 25000000;
   localparam int CARRIER_HZ = 500000;
   localparam logic [4:0] CARRIER_HALF = 5'(CLK_HZ / (2 * CARRIER_HZ));
   // infrared mode select codes
   localparam logic [1:0] IR_PULSE = 2'h1;
   localparam logic [1:0] IR_CARRIER = 2'h2;
endpackage : uart_pkg

/* uart_fifo_infrared_channel.sv */
// serial channel with 16-byte queues and infrared encoding
`timescale 1ns/1ns
module uart_fifo_infrared_channel (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [2:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [7:0] rd_data,
   output logic irq,
   input wire logic xt_mode,
   input wire logic [1:0] ir_mode,
   input wire logic half_duplex,
   input wire logic rx_in,
   input wire logic ir_rx_in,
   input wire logic cts_n,
   input wire logic dsr_n,
   input wire logic ri_n,
   input wire logic dcd_n,
   output logic tx_out,
   output logic ir_tx_out,
   output logic rts_n,
   output logic dtr_n
);
   // queue capacity: full depth in fifo mode, one slot otherwise
   function automatic logic [4:0] cap_of(input logic fen);
      return fen ? uart_pkg::FIFO_DEPTH : uart_pkg::ONE_SLOT;
   endfunction : cap_of

   // mask of valid data bits for the word length code
   function automatic logic [7:0] dmask_of(input logic [1:0] wl);
      return 8'hff >> (2'h3 - wl);
   endfunction : dmask_of

   // bits in a frame: start, data, parity, stop
   function automatic logic [3:0] len_of(input logic [7:0] lc);
      return uart_pkg::BASE_BITS + {2'h0, lc[1:0]}
         + {3'h0, lc[uart_pkg::LCR_PAR_EN]} + {3'h0, lc[uart_pkg::LCR_STOP]};
   endfunction : len_of

   // parity bit for masked data under line control settings
   function automatic logic par_of(input logic [7:0] m,
                                   input logic [7:0] lc);
      if (lc[uart_pkg::LCR_STICK]) begin
         return ~lc[uart_pkg::LCR_EVEN];
      end
      return lc[uart_pkg::LCR_EVEN] ? ^m : ~^m;
   endfunction : par_of

   // serial frame, start bit in bit 0, lsb data next
   function automatic logic [11:0] frame_of(input logic [7:0] d,
                                            input logic [7:0] lc);
      logic [11:0] f;
      logic [7:0] m;
      int n;
      m = d & dmask_of(lc[1:0]);
      n = 5 + int'(lc[1:0]);
      f = {3'h7, m | ~dmask_of(lc[1:0]), 1'b0};
      if (lc[uart_pkg::LCR_PAR_EN]) begin
         f[n + 1] = par_of(m, lc);
      end
      return f;
   endfunction : frame_of

   typedef enum logic {TX_IDLE, TX_SEND} tx_state_e;

   // host registers
   logic [3:0] ier_r;  // interrupt enables
   logic [7:0] lcr_r;  // line control
   logic [4:0] mcr_r;  // modem control incl. aux bits
   logic [7:0] scr_r;  // scratch
   logic [15:0] div_r;  // divisor latch
   logic fifo_en_r;  // fifo mode
   logic [1:0] trig_r;  // receive trigger code
   // pin synchronisers
   logic [5:0] sync1_r;
   logic [5:0] sync2_r;
   // baud tick generator
   logic [15:0] bcnt_r;
   // carrier generator
   logic [4:0] car_cnt_r;
   logic car_ph_r;
   // transmit queue and shifter
   logic [7:0] txq [16];
   logic [3:0] txw_r, txr_r;
   logic [4:0] txc_r;
   tx_state_e tx_st_r;
   logic [11:0] tx_frm_r;
   logic [3:0] tx_left_r, tx_ph_r;
   // transmit interrupt hold-off
   logic tx_holding_empty_arm_r, tx_holding_empty_ok_r;
   logic [7:0] hold_cnt_r;
   // receive queue and shifter
   logic [10:0] rxq [16];
   logic [3:0] rxw_r, rxr_r;
   logic [4:0] rxc_r;
   logic rx_busy_r;
   logic [11:0] rx_sh_r;
   logic [3:0] rx_left_r, rx_ph_r, rx_len_r;
   logic oe_r;  // overrun, sticky
   logic [9:0] idle_cnt_r;
   logic to_r;  // character timeout pending
   // half duplex turnaround
   logic [9:0] turn_cnt_r;
   logic last_rx_r;  // last character was received
   // modem status
   logic [3:0] mdm_prev_r, dlt_r;
   logic [7:0] rd_data_r;
   logic irq_r, tx_out_r, ir_out_r, rts_n_r, dtr_n_r;

   // host access decode
   wire dsel = lcr_r[uart_pkg::LCR_DIV_SEL];
   wire wr_thr = wr_stb && addr == uart_pkg::OFS_DATA && !dsel;
   wire wr_dll = wr_stb && addr == uart_pkg::OFS_DATA && dsel;
   wire wr_ier = wr_stb && addr == uart_pkg::OFS_IER && !dsel;
   wire wr_dlm = wr_stb && addr == uart_pkg::OFS_IER && dsel;
   wire wr_fcr = wr_stb && addr == uart_pkg::OFS_IIR;
   wire wr_lcr = wr_stb && addr == uart_pkg::OFS_LCR;
   wire wr_mcr = wr_stb && addr == uart_pkg::OFS_MCR;
   wire wr_scr = wr_stb && addr == uart_pkg::OFS_SCR && !xt_mode;
   wire rd_rbr = rd_stb && addr == uart_pkg::OFS_DATA && !dsel;
   wire rd_lsr = rd_stb && addr == uart_pkg::OFS_LSR;
   wire rd_msr = rd_stb && addr == uart_pkg::OFS_MSR;

   // synchronised pins
   wire rx_s = sync2_r[5];
   wire ir_rx_s = sync2_r[4];
   wire loop = mcr_r[uart_pkg::MCR_LOOP];
   wire tick = bcnt_r == 16'h0000;

   // transmit path
   wire [4:0] cap = cap_of(fifo_en_r);
   wire tx_empty = txc_r == 5'h00;
   wire tx_busy = tx_st_r == TX_SEND;
   wire tx_push = wr_thr && txc_r < cap;
   wire turn_busy = turn_cnt_r != 10'h000;
   wire tx_hold = half_duplex && (rx_busy_r || (turn_busy && last_rx_r));
   wire tx_go = !tx_busy && !tx_empty && !tx_hold;
   wire tx_done = tx_busy && tick && tx_ph_r == uart_pkg::BIT_LAST
      && tx_left_r == 4'h1;
   wire tx_bit = tx_busy ? tx_frm_r[0] : 1'b1;
   wire tx_flush = wr_fcr && (wr_data[uart_pkg::FCR_TX_RST]
      || wr_data[uart_pkg::FCR_EN] != fifo_en_r);
   wire tx_holding_empty_src = tx_empty && tx_holding_empty_ok_r;

   // receive path
   wire rx_blocked = half_duplex && turn_busy && !last_rx_r;
   wire rx_raw = loop ? tx_bit
      : (ir_mode != 2'h0 ? ir_rx_s : rx_s);
   wire rx_line = (rx_blocked && !rx_busy_r) ? 1'b1 : rx_raw;
   wire rx_sample = rx_busy_r && tick && rx_ph_r == uart_pkg::BIT_MID;
   wire rx_done = rx_sample && rx_left_r == 4'h1 && rx_len_r != rx_left_r;
   wire rx_full = rxc_r >= cap;
   wire rx_push = rx_done && !rx_full;
   wire rx_pop = rd_rbr && rxc_r != 5'h00;
   wire rx_flush = wr_fcr && (wr_data[uart_pkg::FCR_RX_RST]
      || wr_data[uart_pkg::FCR_EN] != fifo_en_r);
   wire [10:0] rx_head = rxq[rxr_r];
   wire rx_any = rxc_r != 5'h00;
   wire [2:0] head_err = rx_any ? rx_head[10:8] : 3'h0;

   // received frame decode
   logic [7:0] rx_data;
   logic [2:0] rx_err;  // break, framing, parity
   always_comb begin
      logic [11:0] f;
      int n;
      int pe;
      // include the bit sampled on this edge, the frame's final stop bit
      f = {rx_line, rx_sh_r[11:1]} >> (uart_pkg::FRAME_W - rx_len_r);
      n = 5 + int'(lcr_r[1:0]);
      pe = int'(lcr_r[uart_pkg::LCR_PAR_EN]);
      rx_data = f[8:1] & dmask_of(lcr_r[1:0]);
      rx_err[0] = pe == 1 && f[n + 1] != par_of(rx_data, lcr_r);
      rx_err[1] = !f[n + 1 + pe];
      rx_err[2] = (f & ~(12'hfff << rx_len_r)) == 12'h000;
   end

   // any error among stored receive entries
   logic err_any;
   always_comb begin
      logic [3:0] k;
      k = 4'h0;
      err_any = 1'b0;
      for (int i = 0; i < 16; i++) begin
         k = 4'(i) - rxr_r;
         if ({1'b0, k} < rxc_r && rxq[i][10:8] != 3'h0) begin
            err_any = 1'b1;
         end
      end
   end

   // trigger level from code
   wire [4:0] trig = trig_r == 2'h0 ? uart_pkg::TRIG_1
      : trig_r == 2'h1 ? uart_pkg::TRIG_4
      : trig_r == 2'h2 ? uart_pkg::TRIG_8 : uart_pkg::TRIG_14;
   wire rx_lvl = fifo_en_r ? rxc_r >= trig : rx_any;

   // modem lines, active high, looped from control bits
   wire [3:0] mdm_now = loop
      ? {mcr_r[uart_pkg::MCR_AUX2], mcr_r[uart_pkg::MCR_AUX1],
         mcr_r[uart_pkg::MCR_DTR], mcr_r[uart_pkg::MCR_RTS]}
      : ~sync2_r[3:0];
   wire [3:0] chg = mdm_now ^ mdm_prev_r;
   wire [3:0] dlt_set = {chg[3], mdm_prev_r[2] & !mdm_now[2],
      chg[1], chg[0]};

   // interrupt priority
   wire line_int = ier_r[2] && (oe_r || head_err != 3'h0);
   wire data_int = ier_r[0] && rx_lvl;
   wire to_int = ier_r[0] && to_r;
   wire tx_holding_empty_int = ier_r[1] && tx_holding_empty_src;
   wire mdm_int = ier_r[3] && dlt_r != 4'h0;
   wire [3:0] iir_code = line_int ? uart_pkg::IIR_LINE
      : data_int ? uart_pkg::IIR_RXDATA
      : to_int ? uart_pkg::IIR_TIMEOUT
      : tx_holding_empty_int ? uart_pkg::IIR_TX_HOLDING_EMPTY
      : mdm_int ? uart_pkg::IIR_MODEM : uart_pkg::IIR_NONE;
   wire [7:0] iir_val = {fifo_en_r, fifo_en_r, 2'h0, iir_code};
   wire [7:0] lsr_val = {fifo_en_r && err_any,
      tx_empty && !tx_busy, tx_empty, head_err[2], head_err[1],
      head_err[0], oe_r, rx_any};
   wire [7:0] msr_val = {mdm_now, dlt_r};

   // read data selection
   wire [7:0] rd_mux = addr == uart_pkg::OFS_DATA
      ? (dsel ? div_r[7:0] : rx_head[7:0])
      : addr == uart_pkg::OFS_IER ? (dsel ? div_r[15:8] : {4'h0, ier_r})
      : addr == uart_pkg::OFS_IIR ? iir_val
      : addr == uart_pkg::OFS_LCR ? lcr_r
      : addr == uart_pkg::OFS_MCR ? {3'h0, mcr_r}
      : addr == uart_pkg::OFS_LSR ? lsr_val
      : addr == uart_pkg::OFS_MSR ? msr_val
      : (xt_mode ? 8'h00 : scr_r);

   // host-writable registers
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ier_r <= 4'h0;
         lcr_r <= 8'h00;
         mcr_r <= 5'h00;
         scr_r <= 8'h00;
         div_r <= 16'h0000;
         fifo_en_r <= 1'b0;
         trig_r <= 2'h0;
      end else if (clk_en) begin
         if (wr_ier) ier_r <= wr_data[3:0];
         if (wr_lcr) lcr_r <= wr_data;
         if (wr_mcr) mcr_r <= wr_data[4:0];
         if (wr_scr) scr_r <= wr_data;
         if (wr_dll) div_r[7:0] <= wr_data;
         if (wr_dlm) div_r[15:8] <= wr_data;
         if (wr_fcr) begin  // dma select bit ignored
            fifo_en_r <= wr_data[uart_pkg::FCR_EN];
            trig_r <= wr_data[7:6];
         end
      end
   end

   // pin synchronisers, baud tick and carrier
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sync1_r <= 6'h3f;
         sync2_r <= 6'h3f;
         bcnt_r <= 16'h0000;
         car_cnt_r <= 5'h00;
         car_ph_r <= 1'b0;
      end else if (clk_en) begin
         sync1_r <= {rx_in, ir_rx_in, dcd_n, ri_n, dsr_n, cts_n};
         sync2_r <= sync1_r;
         if (wr_dll || wr_dlm) begin
            bcnt_r <= 16'h0000;  // new divisor takes effect at once
         end else begin
            bcnt_r <= tick ? div_r - 16'h0001 : bcnt_r - 16'h0001;
         end
         if (car_cnt_r == uart_pkg::CARRIER_HALF - 5'h01) begin
            car_cnt_r <= 5'h00;
            car_ph_r <= !car_ph_r;
         end else begin
            car_cnt_r <= car_cnt_r + 5'h01;
         end
      end
   end

   // transmit queue storage
   always_ff @(posedge ref_clk) begin
      if (clk_en && tx_push) txq[txw_r] <= wr_data;
   end

   // transmit queue pointers
   always_ff @(posedge ref_clk) begin
      if (reset || (clk_en && tx_flush)) begin
         txw_r <= 4'h0;
         txr_r <= 4'h0;
         txc_r <= 5'h00;
      end else if (clk_en) begin
         if (tx_push) txw_r <= txw_r + 4'h1;
         if (tx_go) txr_r <= txr_r + 4'h1;
         txc_r <= txc_r + {4'h0, tx_push} - {4'h0, tx_go};
      end
   end

   // transmit shifter, lsb first after start bit
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         tx_st_r <= TX_IDLE;
         tx_frm_r <= 12'hfff;
         tx_left_r <= 4'h0;
         tx_ph_r <= 4'h0;
      end else if (clk_en) begin
         case (tx_st_r)
            TX_IDLE: begin
               if (tx_go) begin
                  tx_st_r <= TX_SEND;
                  tx_frm_r <= frame_of(txq[txr_r], lcr_r);
                  tx_left_r <= len_of(lcr_r);
                  tx_ph_r <= 4'h0;
               end
            end
            TX_SEND: begin
               if (tick) begin
                  tx_ph_r <= tx_ph_r + 4'h1;
                  if (tx_ph_r == uart_pkg::BIT_LAST) begin
                     tx_frm_r <= {1'b1, tx_frm_r[11:1]};
                     tx_left_r <= tx_left_r - 4'h1;
                     if (tx_left_r == 4'h1) tx_st_r <= TX_IDLE;
                  end
               end
            end
            default: tx_st_r <= TX_IDLE;
         endcase
      end
   end

   // transmit-empty interrupt hold-off
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         tx_holding_empty_arm_r <= 1'b0;
         tx_holding_empty_ok_r <= 1'b1;
         hold_cnt_r <= 8'h00;
      end else if (clk_en) begin
         if (tx_push && tx_empty) begin
            tx_holding_empty_arm_r <= 1'b1;
            tx_holding_empty_ok_r <= 1'b0;
         end else if (txc_r >= 5'h02) begin
            tx_holding_empty_arm_r <= 1'b0;
         end
         if (!(tx_push && tx_empty) && tx_empty && !tx_holding_empty_ok_r) begin
            if (!tx_holding_empty_arm_r) begin
               tx_holding_empty_ok_r <= 1'b1;
            end else if (hold_cnt_r == uart_pkg::CHAR_TICKS) begin
               tx_holding_empty_ok_r <= 1'b1;
            end else if (tick) begin
               hold_cnt_r <= hold_cnt_r + 8'h01;
            end
         end else begin
            hold_cnt_r <= 8'h00;
         end
      end
   end

   // receive shifter, samples mid bit
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rx_busy_r <= 1'b0;
         rx_sh_r <= 12'h000;
         rx_left_r <= 4'h0;
         rx_ph_r <= 4'h0;
         rx_len_r <= 4'h0;
      end else if (clk_en) begin
         if (!rx_busy_r) begin
            if (!rx_line) begin
               rx_busy_r <= 1'b1;
               rx_ph_r <= 4'h0;
               rx_left_r <= len_of(lcr_r);
               rx_len_r <= len_of(lcr_r);
            end
         end else if (tick) begin
            rx_ph_r <= rx_ph_r + 4'h1;
            if (rx_ph_r == uart_pkg::BIT_MID) begin
               rx_sh_r <= {rx_line, rx_sh_r[11:1]};
               rx_left_r <= rx_left_r - 4'h1;
               // false start or final stop bit ends the frame
               if ((rx_left_r == rx_len_r && rx_line)
                  || rx_left_r == 4'h1) rx_busy_r <= 1'b0;
            end
         end
      end
   end

   // receive queue storage
   always_ff @(posedge ref_clk) begin
      if (clk_en && rx_push) rxq[rxw_r] <= {rx_err, rx_data};
   end

   // receive queue pointers and overrun
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         oe_r <= 1'b0;
      end else if (clk_en) begin
         if (rx_done && rx_full) oe_r <= 1'b1;
         else if (rd_lsr) oe_r <= 1'b0;
      end
      if (reset || (clk_en && rx_flush)) begin
         rxw_r <= 4'h0;
         rxr_r <= 4'h0;
         rxc_r <= 5'h00;
      end else if (clk_en) begin
         if (rx_push) rxw_r <= rxw_r + 4'h1;
         if (rx_pop) rxr_r <= rxr_r + 4'h1;
         rxc_r <= rxc_r + {4'h0, rx_push} - {4'h0, rx_pop};
      end
   end

   // character timeout
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         idle_cnt_r <= 10'h000;
         to_r <= 1'b0;
      end else if (clk_en) begin
         if (rx_push || rx_pop || !rx_any || !fifo_en_r) begin
            idle_cnt_r <= 10'h000;
            to_r <= 1'b0;
         end else if (idle_cnt_r == uart_pkg::TIMEOUT_TICKS) begin
            to_r <= 1'b1;
         end else if (tick) begin
            idle_cnt_r <= idle_cnt_r + 10'h001;
         end
      end
   end

   // half duplex turnaround timer
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         turn_cnt_r <= 10'h000;
         last_rx_r <= 1'b0;
      end else if (clk_en) begin
         if (half_duplex && (tx_done || rx_done)) begin
            turn_cnt_r <= uart_pkg::TURN_TICKS;
            last_rx_r <= rx_done;
         end else if (tick && turn_busy) begin
            turn_cnt_r <= turn_cnt_r - 10'h001;
         end
      end
   end

   // modem status deltas, set wins over read clear
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         mdm_prev_r <= 4'h0;
         dlt_r <= 4'h0;
      end else if (clk_en) begin
         mdm_prev_r <= mdm_now;
         dlt_r <= dlt_set | (rd_msr ? 4'h0 : dlt_r);
      end
   end

   // registered outputs and line encoding
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rd_data_r <= 8'h00;
         irq_r <= 1'b0;
         tx_out_r <= 1'b1;
         ir_out_r <= 1'b0;
         rts_n_r <= 1'b1;
         dtr_n_r <= 1'b1;
      end else if (clk_en) begin
         if (rd_stb) rd_data_r <= rd_mux;
         irq_r <= !iir_code[0];
         tx_out_r <= loop || (tx_bit && !lcr_r[uart_pkg::LCR_BREAK]);
         if (loop || tx_bit) begin
            ir_out_r <= 1'b0;
         end else if (ir_mode == uart_pkg::IR_PULSE) begin
            ir_out_r <= tx_ph_r < uart_pkg::IRDA_PULSE_TICKS;
         end else if (ir_mode == uart_pkg::IR_CARRIER) begin
            ir_out_r <= car_ph_r;
         end else begin
            ir_out_r <= 1'b0;
         end
         rts_n_r <= loop || !mcr_r[uart_pkg::MCR_RTS];
         dtr_n_r <= loop || !mcr_r[uart_pkg::MCR_DTR];
      end
   end

   assign rd_data = rd_data_r;
   assign irq = irq_r;
   assign tx_out = tx_out_r;
   assign ir_tx_out = ir_out_r;
   assign rts_n = rts_n_r;
   assign dtr_n = dtr_n_r;
endmodule : uart_fifo_infrared_channel

/* uart_chk_props.sv */
// port checker for the infrared serial channel
`timescale 1ns/1ns
module uart_chk (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic xt_mode,
   input wire logic [2:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] rd_data,
   input wire logic [1:0] ir_mode,
   input wire logic tx_out,
   input wire logic ir_tx_out,
   input wire logic rts_n,
   input wire logic dtr_n,
   input wire logic irq
);
   logic dsel_r, fifo_r; // divisor select, fifo mode shadows
   logic [7:0] mcr_r; // modem control shadow
   logic [5:0] hi_cnt; // length of current infrared high run
   // shadow the host writes
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         dsel_r <= 1'b0;
         fifo_r <= 1'b0;
         mcr_r <= 8'h00;
      end else if (wr_stb) begin
         if (addr == uart_pkg::OFS_LCR) dsel_r <= wr_data[7];
         if (addr == uart_pkg::OFS_IIR) fifo_r <= wr_data[0];
         if (addr == uart_pkg::OFS_MCR) mcr_r <= wr_data;
      end
   end
   // count high cycles of the infrared output
   always_ff @(posedge ref_clk)
      hi_cnt <= ir_tx_out ? hi_cnt + 6'h01 : 6'h00;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   AST_RESET_OUT: assert property (disable iff (1'b0) reset |=>
      tx_out && rts_n && dtr_n && !irq && !ir_tx_out) else $error("busy reset");
   AST_RD_HOLD: assert property (!rd_stb |=> $stable(rd_data))
      else $error("read data moved");
   AST_IIR_FIFO: assert property (
      rd_stb && addr == uart_pkg::OFS_IIR |=>
      rd_data[7:6] == {2{fifo_r}} && (fifo_r || !rd_data[3]))
      else $error("fifo bits wrong");
   AST_SCR_XT: assert property (
      rd_stb && addr == uart_pkg::OFS_SCR && xt_mode |=> rd_data == 8'h00)
      else $error("scratch visible");
   AST_MCR_PINS: assert property (
      wr_stb && addr == uart_pkg::OFS_MCR && !wr_data[4]
      |=> ##1 rts_n == !mcr_r[1] && dtr_n == !mcr_r[0])
      else $error("modem pins wrong");
   AST_TX_START: assert property (
      wr_stb && addr == uart_pkg::OFS_DATA && !dsel_r && ir_mode == 2'h0
      |-> ##[1:1000] !tx_out)
      else $error("no start bit");
   AST_PULSE: assert property (
      $rose(ir_tx_out) && ir_mode == uart_pkg::IR_PULSE
      |-> ir_tx_out [*3] ##1 !ir_tx_out)
      else $error("pulse width wrong");
   AST_CARRIER: assert property (
      $fell(ir_tx_out) && ir_mode == uart_pkg::IR_CARRIER |-> hi_cnt <= 6'h19)
      else $error("carrier half too long");
endmodule : uart_chk
bind uart_fifo_infrared_channel uart_chk u_chk (.ref_clk(ref_clk),
   .reset(reset), .wr_stb(wr_stb), .rd_stb(rd_stb), .xt_mode(xt_mode),
   .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .ir_mode(ir_mode),
   .tx_out(tx_out), .ir_tx_out(ir_tx_out), .rts_n(rts_n), .dtr_n(dtr_n),
   .irq(irq));

/* remote_serial.sv */
// remote serial device model on the line side
`timescale 1ns/1ns
module remote_serial #(parameter int BIT_CLK = 16) (
   input wire logic ref_clk,
   input wire logic line_in,
   output logic line_out
);
   logic [7:0] rx_last; // last byte seen
   int rx_cnt; // bytes seen
   initial line_out = 1'b1;
   // frame one byte, lsb first, one stop bit
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(negedge ref_clk) line_out = f[i];
         repeat (BIT_CLK - 1) @(negedge ref_clk);
      end
   endtask : send
   // sample each incoming frame mid-bit
   initial begin
      rx_cnt = 0;
      forever begin
         @(negedge line_in);
         repeat (BIT_CLK / 2) @(posedge ref_clk);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLK) @(posedge ref_clk);
            rx_last[i] = line_in;
         end
         repeat (BIT_CLK) @(posedge ref_clk);
         rx_cnt++;
      end
   end
endmodule : remote_serial

/* tb.sv */
// self-checking bench for the infrared serial channel
`timescale 1ns/1ns
module tb;
   logic ref_clk = 1'b0, reset = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0;
   logic xt_mode = 1'b0, ser, irq, tx_out, ir_tx_out, rts_n, dtr_n;
   logic [1:0] ir_mode = 2'h0;
   logic half_duplex = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wr_data = 8'h00, rd_data;
   int err_count = 0, num_checks = 0;
   always #20 ref_clk = ~ref_clk;
   uart_fifo_infrared_channel uut (.ref_clk(ref_clk), .reset(reset),
      .clk_en(1'b1), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rd_data(rd_data), .irq(irq), .xt_mode(xt_mode),
      .ir_mode(ir_mode), .half_duplex(half_duplex), .rx_in(ser),
      .ir_rx_in(ser), .cts_n(rts_n), .dsr_n(dtr_n), .ri_n(1'b1), .dcd_n(1'b1),
      .tx_out(tx_out), .ir_tx_out(ir_tx_out), .rts_n(rts_n), .dtr_n(dtr_n));
   remote_serial u_rem (.ref_clk(ref_clk), .line_in(tx_out), .line_out(ser));
   task automatic chk(input logic [7:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      addr = a;
      wr_data = d;
      wr_stb = 1'b1;
      @(negedge ref_clk);
      wr_stb = 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(negedge ref_clk);
      addr = a;
      rd_stb = 1'b1;
      @(negedge ref_clk);
      rd_stb = 1'b0;
      chk(rd_data, e);
   endtask : rd
   task automatic conclude;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   // watchdog
   initial begin
      #(40 * 20000);
      err_count++;
      conclude();
   end
   initial begin
      repeat (5) @(negedge ref_clk);
      reset = 1'b0;
      rd(uart_pkg::OFS_LSR, 8'h60);
      rd(uart_pkg::OFS_IIR, 8'h01);
      wr(uart_pkg::OFS_LCR, 8'h83);
      wr(uart_pkg::OFS_DATA, 8'h01);
      wr(uart_pkg::OFS_IER, 8'h00);
      rd(uart_pkg::OFS_DATA, 8'h01);
      wr(uart_pkg::OFS_LCR, 8'h03);
      wr(uart_pkg::OFS_SCR, 8'ha5);
      xt_mode = 1'b1;
      rd(uart_pkg::OFS_SCR, 8'h00);
      xt_mode = 1'b0;
      rd(uart_pkg::OFS_SCR, 8'ha5);
      wr(uart_pkg::OFS_MCR, 8'h0e);
      rd(uart_pkg::OFS_MCR, 8'h0e);
      chk({6'h00, rts_n, dtr_n}, 8'h01);
      wr(uart_pkg::OFS_IIR, 8'h49);
      rd(uart_pkg::OFS_IIR, 8'hc1);
      wr(uart_pkg::OFS_IER, 8'h01);
      // seventeen bytes: trigger at four, overrun at the last
      for (int i = 0; i < 17; i++) begin
         u_rem.send(8'h31 + 8'(i));
         if (i > 1 && i < 4) chk({7'h00, irq}, 8'(i == 3));
      end
      rd(uart_pkg::OFS_LSR, 8'h63);
      for (int i = 0; i < 16; i++) begin
         rd(uart_pkg::OFS_DATA, 8'h31 + 8'(i));
      end
      u_rem.send(8'h5a);
      repeat (600) @(negedge ref_clk);
      rd(uart_pkg::OFS_IIR, 8'hc1);
      repeat (100) @(negedge ref_clk);
      rd(uart_pkg::OFS_IIR, 8'hcc);
      rd(uart_pkg::OFS_DATA, 8'h5a);
      rd(uart_pkg::OFS_IIR, 8'hc1);
      wr(uart_pkg::OFS_IER, 8'h02);
      repeat (2) @(negedge ref_clk);
      chk({7'h00, irq}, 8'h01);
      wr(uart_pkg::OFS_DATA, 8'h96);
      repeat (2) @(negedge ref_clk);
      chk({7'h00, irq}, 8'h00);
      repeat (100) @(negedge ref_clk);
      chk({7'h00, irq}, 8'h00);
      repeat (100) @(negedge ref_clk);
      chk({7'h00, irq}, 8'h01);
      repeat (200) @(negedge ref_clk);
      chk(u_rem.rx_last, 8'h96);
      // eighteen writes: one refused while the queue is full
      for (int i = 0; i < 18; i++) wr(uart_pkg::OFS_DATA, 8'(i));
      repeat (3000) @(negedge ref_clk);
      chk(8'(u_rem.rx_cnt), 8'h12);
      chk(u_rem.rx_last, 8'h10);
      ir_mode = uart_pkg::IR_PULSE;
      wr(uart_pkg::OFS_DATA, 8'h00);
      repeat (200) @(negedge ref_clk);
      // half duplex: transmit waits out the turnaround after a reception
      half_duplex = 1'b1;
      u_rem.send(8'h77);
      wr(uart_pkg::OFS_DATA, 8'h55);
      repeat (100) @(negedge ref_clk);
      chk({7'h00, tx_out}, 8'h01);
      rd(uart_pkg::OFS_DATA, 8'h77);
      repeat (860) @(negedge ref_clk);
      chk(u_rem.rx_last, 8'h55);
      // a byte arriving in the turnaround after sending is kept out
      u_rem.send(8'h66);
      rd(uart_pkg::OFS_LSR, 8'h60);
      half_duplex = 1'b0;
      ir_mode = uart_pkg::IR_CARRIER;
      wr(uart_pkg::OFS_LCR, 8'h83);
      wr(uart_pkg::OFS_DATA, 8'h04);
      wr(uart_pkg::OFS_LCR, 8'h03);
      wr(uart_pkg::OFS_DATA, 8'h00);
      repeat (800) @(negedge ref_clk);
      conclude();
   end
endmodule : tb
